/* rtd_adder.sv */
// Purpose: bit-sliced adder with per-slice carry and lab-mode carry block
// Assumes: inputs already gated by the enable network
// Notes: purely combinational
`timescale 1ns/1ns
module rtd_adder
   import rtd_pkg::*;
#(
   parameter int W = WORD_W
) (
   input wire logic [W-1:0] opA,
   input wire logic [W-1:0] opB,
   input wire logic carryIn,
   input wire logic labMode,
   output logic [W-1:0] sum,
   output logic carryOut
);
   logic [W:0] carry;
   assign carry[0] = carryIn;
   for (genvar i = 0; i < W; i++) begin : g_slice
      wire logic cgen;
      assign sum[i] = opA[i] ^ opB[i] ^ carry[i];
      assign cgen = (opA[i] & opB[i]) | (carry[i] & (opA[i] ^ opB[i]));
      assign carry[i+1] = cgen & ~(labMode && i == LAB_CARRY_STOP);
   end
   assign carryOut = carry[W];
endmodule : rtd_adder

/* rtd_datapath.sv */
// Purpose: 12-bit register transfer datapath with skip and field logic
// Assumes: time pulses are single-cycle strobes from the sequencer on core_clk
// Notes: switches, sense and break address lines are synchronised here
`timescale 1ns/1ns
module rtd_datapath
   import rtd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic laboratoryMode,
   input wire logic firstTimePulse,
   input wire logic thirdTimePulse,
   input wire logic manualSecondTimePulse,
   input wire logic fifthTimeState,
   input wire logic secondExecuteState,
   input wire logic indirectState,
   input wire logic fetchState,
   input wire logic enAccumulator,
   input wire logic enAccumHalfL,
   input wire logic enAccumHalfR,
   input wire logic halfWordOp,
   input wire logic complementAccOp,
   input wire logic enInstrHi,
   input wire logic enInstrLo,
   input wire logic [1:0] enAddrGroups,
   input wire logic [1:0] enBufferGroups,
   input wire logic [1:0] enSenseGroups,
   input wire logic enProgramCounter,
   input wire logic rightSwitchEnable,
   input wire logic breakAddressEnable,
   input wire logic breakRequest,
   input wire logic [1:0] shiftSel,
   input wire logic setOp,
   input wire logic multiplyOp,
   input wire logic clearOp,
   input wire logic diskShiftOp,
   input wire logic extendedArithmeticOp,
   input wire logic rotateOp,
   input wire logic mqShiftLeft,
   input wire logic mqShiftRight,
   input wire logic loadAccumulator,
   input wire logic loadProgramCounter,
   input wire logic loadInstruction,
   input wire logic skipInstr,
   input wire logic skipOnEqual,
   input wire logic labSkipInstr,
   input wire logic useExternalSense,
   input wire logic [3:0] senseSel,
   input wire logic [13:0] internalSkips,
   input wire logic [11:0] extSkipLevels,
   input wire logic clearSkipFlags,
   input wire logic loadInstructionFieldOp,
   input wire logic [1:0] requestedField,
   input wire logic jumpOp,
   input wire logic [11:0] jumpTarget,
   input wire logic [11:0] senseRegister,
   input wire logic [11:0] rightSwitches,
   input wire logic [11:0] breakAddress,
   output logic [11:0] accumulator,
   output logic [11:0] memoryBufferRegister,
   output logic [11:0] memoryAddressRegister,
   output logic [11:0] multiplierQuotientRegister,
   output logic [11:0] programCounter,
   output logic [11:0] instructionRegister,
   output logic [1:0] instructionField,
   output logic [1:0] dataField,
   output logic [1:0] instructionFieldBuffer,
   output logic [1:0] saveInstrField,
   output logic [1:0] saveDataField,
   output logic skipFlag,
   output logic halfFlag,
   output logic accEqualsBuffer
);

   function automatic logic [11:0] gate(input logic en, input logic [11:0] v);
      gate = en ? v : WORD_ZERO;
   endfunction : gate

   function automatic logic [11:0] grpMask(input logic [1:0] g);
      grpMask = (g[1] ? HALF_L_MASK : WORD_ZERO) | (g[0] ? HALF_R_MASK : WORD_ZERO);
   endfunction : grpMask

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: switches, break lines and sense levels are async
   logic [11:0] swS1_r, swS2_r, baS1_r, baS2_r, xlS1_r, xlS2_r;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         swS1_r <= WORD_ZERO;
         swS2_r <= WORD_ZERO;
         baS1_r <= WORD_ZERO;
         baS2_r <= WORD_ZERO;
         xlS1_r <= WORD_ZERO;
         xlS2_r <= WORD_ZERO;
      end else if (clkEn) begin
         swS1_r <= rightSwitches;
         swS2_r <= swS1_r;
         baS1_r <= breakAddress;
         baS2_r <= baS1_r;
         xlS1_r <= extSkipLevels;
         xlS2_r <= xlS1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   logic [11:0] acc_r, mb_r, ma_r, mq_r, pc_r, ir_r;
   logic [1:0] if_r, df_r, ib_r, sif_r, sdf_r;
   logic skip_r, half_r, eq_r;

   ////////////////////////////////////////////////////////////////////////////
   // adder input A: accumulator side
   // half-word accumulator gating
   wire logic [11:0] accHalves = (acc_r & (enAccumHalfL ? HALF_L_MASK : WORD_ZERO))
      | (acc_r & (enAccumHalfR ? HALF_R_MASK : WORD_ZERO));
   wire logic [11:0] accPlain = halfWordOp ? accHalves : gate(enAccumulator, acc_r);
   wire logic enAccComp = (fifthTimeState && !complementAccOp) || (complementAccOp && !laboratoryMode);
   wire logic [11:0] opA = enAccComp ? ~acc_r : accPlain;

   // adder input B: the other main sources, wired-or as in the enable network
   // instruction field groups
   wire logic [11:0] irGated = (ir_r & (enInstrHi ? IR_HI_MASK : WORD_ZERO))
      | (ir_r & (enInstrLo ? IR_LO_MASK : WORD_ZERO));
   // counter field bits held back in lab mode
   wire logic [11:0] pcGated = gate(enProgramCounter, pc_r & (laboratoryMode ? PC_LAB_MASK : WORD_ONES));
   wire logic [11:0] grpGated = (ma_r & grpMask(enAddrGroups)) | (mb_r & grpMask(enBufferGroups))
      | (senseRegister & grpMask(enSenseGroups));
   wire logic [11:0] extGated = gate(rightSwitchEnable, swS2_r)
      | gate(breakAddressEnable && breakRequest, baS2_r);
   wire logic [11:0] opB = irGated | pcGated | grpGated | extGated;

   ////////////////////////////////////////////////////////////////////////////
   // carry insert increments, driven by the skip flag in fetch
   wire logic carryInsert = skip_r && fetchState;
   wire logic [11:0] sum;
   rtd_adder #(.W(WORD_W)) u_adder (
      .opA(opA),
      .opB(opB),
      .carryIn(carryInsert),
      .labMode(laboratoryMode),
      .sum(sum),
      .carryOut()
   );

   // one-hot shift selection; illegal code falls back to no shift
   wire logic shNone = (shiftSel != SH_RIGHT) && (shiftSel != SH_LEFT);
   wire logic shRight = shiftSel == SH_RIGHT;
   wire logic shLeft = shiftSel == SH_LEFT;
   wire logic [11:0] regBus = shRight ? {1'b0, sum[11:1]} : shLeft ? {sum[10:0], 1'b0} : sum;

   ////////////////////////////////////////////////////////////////////////////
   // load pulses
   // buffer load at third pulse
   wire logic loadMb = thirdTimePulse && !(setOp && secondExecuteState);
   wire logic loadMa = manualSecondTimePulse || firstTimePulse;
   wire logic loadMq = multiplyOp || clearOp || (diskShiftOp && secondExecuteState)
      || extendedArithmeticOp || rotateOp;
   wire logic [11:0] mqNxt = mqShiftLeft ? {mq_r[10:0], acc_r[11]}
      : mqShiftRight ? {acc_r[0], mq_r[11:1]} : acc_r;

   wire logic eqNow = acc_r == mb_r;
   wire logic intSense = (senseSel < SKSEL_W'(INT_SKIPS)) ? internalSkips[senseSel] : 1'b0;
   wire logic extSense = (senseSel < SKSEL_W'(EXT_SKIPS)) ? xlS2_r[senseSel]
      : internalSkips[senseSel - SKSEL_W'(EXT_SKIPS)];
   wire logic fetchSkipCondition = labSkipInstr && (useExternalSense ? extSense : intSense)
      && ir_r[IR_IBIT];
   wire logic skipTrue = (skipInstr && ((skipOnEqual && eqNow) || !skipOnEqual)) || fetchSkipCondition;
   wire logic halfSet = indirectState && mb_r[MB_HBIT];
   wire logic jumpTakeField = jumpOp && (jumpTarget != WORD_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // registers hold without load
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         acc_r <= WORD_ZERO;
         mb_r <= WORD_ZERO;
         ma_r <= WORD_ZERO;
         mq_r <= WORD_ZERO;
         pc_r <= WORD_ZERO;
         ir_r <= WORD_ZERO;
      end else if (clkEn) begin
         if (loadAccumulator) acc_r <= regBus;
         if (loadMb) mb_r <= regBus;
         if (loadMa) ma_r <= regBus;
         if (loadMq) mq_r <= mqNxt;
         if (loadProgramCounter) pc_r <= regBus;
         if (loadInstruction) ir_r <= regBus;
      end
   end

   // skip and half flags; clear is synchronous, set wins in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         skip_r <= 1'b0;
         half_r <= 1'b0;
         eq_r <= 1'b0;
      end else if (clkEn) begin
         eq_r <= eqNow;
         skip_r <= skipTrue | (skip_r & ~clearSkipFlags);
         half_r <= halfSet | (half_r & ~clearSkipFlags);
      end
   end

   // field logic: buffer holds until a load field op, field takes the buffer on a jump with a nonzero target
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         if_r <= 2'h0;
         df_r <= 2'h0;
         ib_r <= 2'h0;
         sif_r <= 2'h0;
         sdf_r <= 2'h0;
      end else if (clkEn) begin
         if (loadInstructionFieldOp) begin
            ib_r <= requestedField;
            sif_r <= if_r;
            sdf_r <= df_r;
         end
         if (jumpTakeField) if_r <= ib_r;
      end
   end

   assign accumulator = acc_r;
   assign memoryBufferRegister = mb_r;
   assign memoryAddressRegister = ma_r;
   assign multiplierQuotientRegister = mq_r;
   assign programCounter = pc_r;
   assign instructionRegister = ir_r;
   assign instructionField = if_r;
   assign dataField = df_r;
   assign instructionFieldBuffer = ib_r;
   assign saveInstrField = sif_r;
   assign saveDataField = sdf_r;
   assign skipFlag = skip_r;
   assign halfFlag = half_r;
   assign accEqualsBuffer = eq_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_mbHold;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && !loadMb) |=> $stable(mb_r);
   endproperty
   a_mbHold: assert property (p_mbHold) else $error("buffer changed without load");
   property p_mbSetExc;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && thirdTimePulse && setOp && secondExecuteState) |=> $stable(mb_r);
   endproperty
   a_mbSetExc: assert property (p_mbSetExc) else $error("buffer loaded on set op");
   property p_skipSet;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && skipTrue) |=> skipFlag;
   endproperty
   a_skipSet: assert property (p_skipSet) else $error("skip flag not set");
   property p_clrSkips;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && clearSkipFlags && !skipTrue && !halfSet) |=> (!skipFlag && !halfFlag);
   endproperty
   a_clrSkips: assert property (p_clrSkips) else $error("skip flags not cleared");
   property p_halfSet;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && indirectState && mb_r[MB_HBIT]) |=> halfFlag;
   endproperty
   a_halfSet: assert property (p_halfSet) else $error("half flag not set");
   property p_eq;
      @(posedge core_clk) disable iff (!rstn)
         clkEn |=> (accEqualsBuffer == $past(acc_r == mb_r));
   endproperty
   a_eq: assert property (p_eq) else $error("compare wrong");
   property p_ifHold;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && !jumpTakeField) |=> $stable(instructionField);
   endproperty
   a_ifHold: assert property (p_ifHold) else $error("field changed without jump");
   property p_lif;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && loadInstructionFieldOp) |=> (instructionFieldBuffer == $past(requestedField)
            && saveInstrField == $past(if_r));
   endproperty
   a_lif: assert property (p_lif) else $error("field load wrong");
   property p_shOne;
      @(posedge core_clk) disable iff (!rstn)
         $onehot({shNone, shRight, shLeft});
   endproperty
   a_shOne: assert property (p_shOne) else $error("shift select not one-hot");
   property p_mqLoad;
      @(posedge core_clk) disable iff (!rstn)
         (clkEn && loadMq && !mqShiftLeft && !mqShiftRight) |=> (mq_r == $past(acc_r));
   endproperty
   a_mqLoad: assert property (p_mqLoad) else $error("quotient not from accumulator");
endmodule : rtd_datapath

/* rtd_datapath_tb.sv */
// Purpose: self-checking bench for the register transfer datapath
// Assumes: inputs change on the falling edge, loads land on the next rising edge
// Notes: synchronised inputs get three edges to settle before they are used
`timescale 1ns/1ns
module rtd_datapath_tb
   import rtd_pkg::*;
;
////////////////////////////////////////////////////////////////////////////////
// stimulus and observed signals
logic core_clk, rstn, clkEn, laboratoryMode, firstTimePulse, thirdTimePulse;
logic manualSecondTimePulse, fifthTimeState, secondExecuteState, indirectState;
logic fetchState, enAccumulator, enAccumHalfL, enAccumHalfR, halfWordOp;
logic complementAccOp, enInstrHi, enInstrLo, enProgramCounter, rightSwitchEnable;
logic breakAddressEnable, breakRequest, setOp, multiplyOp, clearOp, diskShiftOp;
logic extendedArithmeticOp, rotateOp, mqShiftLeft, mqShiftRight, loadAccumulator;
logic loadProgramCounter, loadInstruction, skipInstr, skipOnEqual, labSkipInstr;
logic useExternalSense, clearSkipFlags, loadInstructionFieldOp, jumpOp;
logic skipFlag, halfFlag, accEqualsBuffer;
logic [1:0] enAddrGroups, enBufferGroups, enSenseGroups, shiftSel, requestedField;
logic [1:0] instructionField, dataField, instructionFieldBuffer, saveInstrField;
logic [1:0] saveDataField;
logic [3:0] senseSel;
logic [13:0] internalSkips;
logic [11:0] extSkipLevels, jumpTarget, senseRegister, rightSwitches, breakAddress;
logic [11:0] accumulator, memoryBufferRegister, memoryAddressRegister;
logic [11:0] multiplierQuotientRegister, programCounter, instructionRegister, v;
int errors = 0;
int comparisons = 0;
int i;

rtd_datapath i_dut (
   .core_clk, .rstn, .clkEn, .laboratoryMode, .firstTimePulse, .thirdTimePulse,
   .manualSecondTimePulse, .fifthTimeState, .secondExecuteState, .indirectState,
   .fetchState, .enAccumulator, .enAccumHalfL, .enAccumHalfR, .halfWordOp,
   .complementAccOp, .enInstrHi, .enInstrLo, .enAddrGroups, .enBufferGroups,
   .enSenseGroups, .enProgramCounter, .rightSwitchEnable, .breakAddressEnable,
   .breakRequest, .shiftSel, .setOp, .multiplyOp, .clearOp, .diskShiftOp,
   .extendedArithmeticOp, .rotateOp, .mqShiftLeft, .mqShiftRight, .loadAccumulator,
   .loadProgramCounter, .loadInstruction, .skipInstr, .skipOnEqual, .labSkipInstr,
   .useExternalSense, .senseSel, .internalSkips, .extSkipLevels, .clearSkipFlags,
   .loadInstructionFieldOp, .requestedField, .jumpOp, .jumpTarget, .senseRegister,
   .rightSwitches, .breakAddress, .accumulator, .memoryBufferRegister,
   .memoryAddressRegister, .multiplierQuotientRegister, .programCounter,
   .instructionRegister, .instructionField, .dataField, .instructionFieldBuffer,
   .saveInstrField, .saveDataField, .skipFlag, .halfFlag, .accEqualsBuffer
);

// free-running 10 MHz clock
always #50 core_clk = ~core_clk;

////////////////////////////////////////////////////////////////////////////////
// drop every strobe and enable but clkEn so each step starts from a quiet bus
task automatic quiet();
   {fifthTimeState, secondExecuteState, indirectState, fetchState, enAccumulator,
    enAccumHalfL, enAccumHalfR, halfWordOp, complementAccOp, enInstrHi, enInstrLo,
    enAddrGroups, enBufferGroups, enSenseGroups, enProgramCounter, rightSwitchEnable,
    breakAddressEnable, breakRequest, shiftSel, setOp, multiplyOp, clearOp,
    diskShiftOp, extendedArithmeticOp, rotateOp, mqShiftLeft, mqShiftRight,
    loadAccumulator, loadProgramCounter, loadInstruction, skipInstr, skipOnEqual,
    labSkipInstr, useExternalSense, clearSkipFlags, loadInstructionFieldOp, jumpOp,
    firstTimePulse, thirdTimePulse, manualSecondTimePulse} = '0;
endtask : quiet

// one rising edge, then back to the falling edge where outputs are settled
task automatic tick();
   @(posedge core_clk);
   @(negedge core_clk);
   quiet();
endtask : tick

task automatic check(input logic [95:0] seen, input logic [95:0] exp);
   comparisons++;
   if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
   end
endtask : check

task automatic complete_run();
   $display("comparisons %0d errors %0d", comparisons, errors);
   if (errors == 0 && comparisons > 0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask : complete_run

task automatic zeroCheck();
   check({accumulator, memoryBufferRegister, memoryAddressRegister,
          multiplierQuotientRegister, programCounter, instructionRegister,
          instructionField, dataField, instructionFieldBuffer, saveInstrField,
          saveDataField, skipFlag, halfFlag, accEqualsBuffer}, 96'h0);
endtask : zeroCheck

// buffer is loaded from the sense register alone, so no adder term leaks in
task automatic setMb(input logic [11:0] val);
   senseRegister = val;
   enSenseGroups = 2'h3;
   thirdTimePulse = 1'b1;
   tick();
endtask : setMb

task automatic loadAcc();
   loadAccumulator = 1'b1;
   tick();
endtask : loadAcc

task automatic toAcc();
   enBufferGroups = 2'h3;
   loadAcc();
endtask : toAcc

// clear the flags, then one lab skip with the given sense selection
task automatic sense(input logic ext, input logic [3:0] sel, input logic exp);
   clearSkipFlags = 1'b1;
   tick();
   useExternalSense = ext;
   senseSel = sel;
   labSkipInstr = 1'b1;
   tick();
   check(skipFlag, exp);
endtask : sense

////////////////////////////////////////////////////////////////////////////////
// a hung run still reaches the verdict
initial begin
   #5000000;
   errors++;
   complete_run();
end

// main sequence
initial begin
   core_clk = 1'b0;
   rstn = 1'b0;
   clkEn = 1'b1;
   laboratoryMode = 1'b0;
   {senseSel, internalSkips, requestedField} = '0;
   {extSkipLevels, jumpTarget, senseRegister, rightSwitches, breakAddress} = '0;
   quiet();
   repeat (3) @(negedge core_clk);
   rstn = 1'b1;
   zeroCheck();
   setMb(12'ha5c);
   check(memoryBufferRegister, 12'ha5c);
   senseRegister = 12'hfff;
   enSenseGroups = 2'h1;
   thirdTimePulse = 1'b1;
   tick();
   check(memoryBufferRegister, 12'h03f);
   setOp = 1'b1;
   secondExecuteState = 1'b1;
   setMb(12'h999);
   check(memoryBufferRegister, 12'h03f);
   check(accumulator, 12'h000);
   $display("test buffer done");
   // adder ripple, lab carry stop, compare
   setMb(12'h3ff);
   toAcc();
   tick();
   check(accEqualsBuffer, 1'b1);
   setMb(12'h001);
   tick();
   check(accEqualsBuffer, 1'b0);
   enAccumulator = 1'b1;
   toAcc();
   check(accumulator, 12'h400);
   setMb(12'h3ff);
   toAcc();
   setMb(12'h001);
   laboratoryMode = 1'b1;
   enAccumulator = 1'b1;
   toAcc();
   check(accumulator, 12'h000);
   laboratoryMode = 1'b0;
   $display("test adder done");
   // shift selection, fill bits left unchecked
   setMb(12'h246);
   shiftSel = SH_RIGHT;
   toAcc();
   check(accumulator[10:0], 11'h123);
   shiftSel = SH_LEFT;
   toAcc();
   check(accumulator[11:1], 11'h246);
   shiftSel = SH_NONE;
   toAcc();
   check(accumulator, 12'h246);
   // complement in fifth state and by the general op
   setMb(12'h0f0);
   toAcc();
   fifthTimeState = 1'b1;
   enAccumulator = 1'b1;
   loadAcc();
   check(accumulator, 12'hf0f);
   complementAccOp = 1'b1;
   enAccumulator = 1'b1;
   loadAcc();
   check(accumulator, 12'h0f0);
   $display("test shift and complement done");
   setMb(12'hfff);
   enBufferGroups = 2'h3;
   loadProgramCounter = 1'b1;
   loadInstruction = 1'b1;
   tick();
   enProgramCounter = 1'b1;
   loadAcc();
   check(accumulator, 12'hfff);
   laboratoryMode = 1'b1;
   enProgramCounter = 1'b1;
   loadAcc();
   check(accumulator, PC_LAB_MASK);
   laboratoryMode = 1'b0;
   enInstrHi = 1'b1;
   loadAcc();
   check(accumulator, IR_HI_MASK);
   enInstrLo = 1'b1;
   loadAcc();
   check(accumulator, IR_LO_MASK);
   for (i = 0; i < 2; i++) begin
      toAcc();
      halfWordOp = 1'b1;
      {enAccumHalfL, enAccumHalfR} = (i == 0) ? 2'h2 : 2'h1;
      loadAcc();
      check(accumulator, (i == 0) ? HALF_L_MASK : HALF_R_MASK);
   end
   $display("test gating done");
   // switches and break address through the synchronisers
   rightSwitches = 12'h5a3;
   breakAddress = 12'h3c6;
   extSkipLevels = 12'h020;
   repeat (3) tick();
   rightSwitchEnable = 1'b1;
   loadAcc();
   check(accumulator, 12'h5a3);
   breakRequest = 1'b1;
   breakAddressEnable = 1'b1;
   loadAcc();
   check(accumulator, 12'h3c6);
   setMb(12'h7e1);
   enBufferGroups = 2'h3;
   manualSecondTimePulse = 1'b1;
   tick();
   check(memoryAddressRegister, 12'h7e1);
   setMb(12'h0ff);
   enBufferGroups = 2'h3;
   firstTimePulse = 1'b1;
   tick();
   check(memoryAddressRegister, 12'h0ff);
   enAddrGroups = 2'h1;
   loadAcc();
   check(accumulator, 12'h03f);
   $display("test address done");
   skipInstr = 1'b1;
   tick();
   check(skipFlag, 1'b1);
   fetchState = 1'b1;
   enAddrGroups = 2'h3;
   firstTimePulse = 1'b1;
   tick();
   check(memoryAddressRegister, 12'h100);
   clearSkipFlags = 1'b1;
   tick();
   check(skipFlag, 1'b0);
   setMb(12'h002);
   skipInstr = 1'b1;
   skipOnEqual = 1'b1;
   tick();
   check(skipFlag, 1'b0);
   setMb(12'h03f);
   tick();
   skipInstr = 1'b1;
   skipOnEqual = 1'b1;
   tick();
   check(skipFlag, 1'b1);
   // lab sense sources qualified by bit 07
   setMb(12'h010);
   enBufferGroups = 2'h3;
   loadInstruction = 1'b1;
   tick();
   laboratoryMode = 1'b1;
   internalSkips = 14'h2008;
   sense(1'b0, 4'h3, 1'b1);
   sense(1'b0, 4'h2, 1'b0);
   sense(1'b0, 4'hd, 1'b1);
   sense(1'b0, 4'he, 1'b0);
   sense(1'b1, 4'h5, 1'b1);
   sense(1'b1, 4'h4, 1'b0);
   sense(1'b1, 4'hf, 1'b1);
   setMb(12'h000);
   enBufferGroups = 2'h3;
   loadInstruction = 1'b1;
   tick();
   sense(1'b0, 4'h3, 1'b0);
   $display("test skip done");
   // half flag from buffer bit 00 in the indirect state
   setMb(12'h800);
   tick();
   check(halfFlag, 1'b0);
   indirectState = 1'b1;
   tick();
   check(halfFlag, 1'b1);
   clearSkipFlags = 1'b1;
   tick();
   check({halfFlag, skipFlag}, 2'h0);
   // field buffer, save fields and jump
   requestedField = 2'h2;
   loadInstructionFieldOp = 1'b1;
   tick();
   check({instructionFieldBuffer, saveInstrField, instructionField}, 6'h20);
   jumpOp = 1'b1;
   tick();
   check(instructionField, 2'h0);
   jumpTarget = 12'h100;
   jumpOp = 1'b1;
   tick();
   check(instructionField, 2'h2);
   requestedField = 2'h1;
   loadInstructionFieldOp = 1'b1;
   tick();
   check({instructionFieldBuffer, saveInstrField, saveDataField}, 6'h18);
   laboratoryMode = 1'b0;
   $display("test fields done");
   // quotient loads from the accumulator, shifts take itself and one accumulator bit
   for (i = 0; i < 5; i++) begin
      v = 12'h0a1 << i;
      setMb(v);
      toAcc();
      {multiplyOp, clearOp, diskShiftOp, extendedArithmeticOp, rotateOp} = 5'h10 >> i;
      secondExecuteState = 1'b1;
      tick();
      check(multiplierQuotientRegister, v);
   end
   multiplyOp = 1'b1;
   mqShiftLeft = 1'b1;
   tick();
   check(multiplierQuotientRegister, 12'h421);
   multiplyOp = 1'b1;
   mqShiftRight = 1'b1;
   tick();
   check(multiplierQuotientRegister, 12'h210);
   setMb(12'h555);
   toAcc();
   check(multiplierQuotientRegister, 12'h210);
   // frozen clock enable, then a second reset in mid-run
   clkEn = 1'b0;
   setMb(12'h777);
   check(memoryBufferRegister, 12'h555);
   clkEn = 1'b1;
   rstn = 1'b0;
   tick();
   rstn = 1'b1;
   zeroCheck();
   $display("test quotient and reset done");
   complete_run();
end
endmodule : rtd_datapath_tb

/* rtd_pkg.sv */
// Purpose: shared constants for the register transfer datapath
// Assumes: 12-bit words, bit 00 is the most significant bit
// Notes: bit numbering follows the machine's msb-first convention
package rtd_pkg;
   localparam int WORD_W = 12;
   localparam logic [11:0] WORD_ZERO = 12'h000;
   localparam logic [11:0] WORD_ONES = 12'hfff;
   // lab mode index arithmetic may not carry past adder bit 2 (lsb index 9)
   localparam int LAB_CARRY_STOP = 9;
   // program counter bits 00-01 hold the field in lab mode
   localparam logic [11:0] PC_LAB_MASK = 12'h3ff;
   // instruction register groups, lsb-indexed
   localparam logic [11:0] IR_HI_MASK = 12'h3f0; // bits 02-07
   localparam logic [11:0] IR_LO_MASK = 12'h00f; // bits 08-11
   localparam logic [11:0] HALF_L_MASK = 12'hfc0;
   localparam logic [11:0] HALF_R_MASK = 12'h03f;
   localparam int IR_IBIT = 4;    // bit 07
   localparam int MB_HBIT = 11;   // bit 00
   localparam int FIELD_W = 2;
   localparam int INT_SKIPS = 14;
   localparam int EXT_SKIPS = 12;
   localparam int EXT_INT_SKIPS = 4;
   localparam int SKSEL_W = 4;
   localparam int SHSEL_W = 2;
   localparam logic [1:0] SH_NONE = 2'h0;
   localparam logic [1:0] SH_RIGHT = 2'h1;
   localparam logic [1:0] SH_LEFT = 2'h2;
endpackage : rtd_pkg
